// *** src/tpu_cfg_pkg.sv ***
// Purpose: Constants for the three-channel timer configuration block
// Assumes: 8-bit registers on a plain strobe port
// Notes: Offsets are register indices on the local port
package tpu_cfg_pkg;
    localparam logic [3:0] ch0_mode_off = 4'h0;
    localparam logic [3:0] ch1_mode_off = 4'h1;
    localparam logic [3:0] ch2_mode_off = 4'h2;
    localparam logic [3:0] ch0_func_ab_off = 4'h3;
    localparam logic [3:0] ch0_func_cd_off = 4'h4;
    localparam logic [3:0] ch1_func_off = 4'h5;
    localparam logic [3:0] ch2_func_off = 4'h6;
    localparam logic [3:0] start_off = 4'h7;
    localparam logic [3:0] sel0_off = 4'h8;
    localparam logic [3:0] sel1_off = 4'h9;
    localparam logic [3:0] sel2_off = 4'ha;
    localparam logic [7:0] mode_reset = 8'hc0;
    localparam logic [7:0] func_reset = 8'h00;
    localparam logic [7:0] mode_fixed_ones = 8'hc0;
    localparam logic [7:0] mode_mask_ch0 = 8'h3f;
    localparam logic [7:0] mode_mask_ch12 = 8'h0f;
    localparam int bfb_pos = 5;
    localparam int bfa_pos = 4;
    localparam int mode_msb = 3;
    localparam logic [3:0] mode_normal = 4'h0;
    localparam logic [3:0] mode_pwm1 = 4'h2;
    localparam logic [3:0] mode_pwm2 = 4'h3;
    // Clock source selections, in the order of the source mux
    typedef enum logic [3:0] {
        src_div1, src_div4, src_div16, src_div64, src_div256, src_div1024,
        src_pin_a, src_pin_b, src_pin_c, src_pin_d, src_phase, src_none
    } clk_src_type;
    localparam logic [9:0] prescale_width_max = 10'h3ff;
endpackage

// *** src/tpu_cfg.sv ***
// Operation
// - Channel 0 codes: phi/1,4,16,64, pins A-D
// - Channel 1: phi/1-64, pins A,B, phi/256
// - Channel 2: phi/1-64, pins A-C, phi/1024
// - Phase counting ignores channel 1/2 clock select
// - Mode registers reset and standby to C0
// - Mode bits 7 and 6 read one
// - Buffer pairing B makes D buffer only
// - Buffer pairing A makes C buffer only
// - Channels 1,2 bits 5,4 read zero
// - Mode field decode normal, PWM, phase
// - Function registers hold two 4-bit nibbles
// - Function registers reset and standby to 00
// - Buffer-assigned C/D function field ignored
// - Initial output level drives while stopped
// - PWM mode 2 level applies at clear
//
// Purpose: Mode, clock source and pin function configuration of a 3-channel timer
// Assumes: Inputs synchronous to clk except external clock pins
// Notes: Clock select bits live in low 3 bits of a per-channel select register
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module tpu_cfg
    import tpu_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hw_standby,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // External clock pins
    input wire logic ext_clk_pin_a,
    input wire logic ext_clk_pin_b,
    input wire logic ext_clk_pin_c,
    input wire logic ext_clk_pin_d,
    // Counter clock enables, one per channel
    output logic [2:0] count_tick,
    // Phase counting active per channel
    output logic [2:0] phase_mode,
    // PWM mode flags per channel
    output logic [2:0] pwm1_mode,
    output logic [2:0] pwm2_mode,
    // Compare/capture enables per general register: ch0 a,b,c,d, ch1 a,b, ch2 a,b
    output logic [7:0] greg_active,
    // Buffer pairing on channel 0
    output logic buf_a_en,
    output logic buf_b_en,
    // Initial pin level per general register, valid while stopped or at PWM2 clear
    output logic [7:0] init_level,
    output logic [7:0] init_level_valid
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] mode0;
        logic [7:0] mode1;
        logic [7:0] mode2;
        logic [7:0] func0ab;
        logic [7:0] func0cd;
        logic [7:0] func1;
        logic [7:0] func2;
        logic [2:0] start;
        logic [2:0] sel0;
        logic [2:0] sel1;
        logic [2:0] sel2;
        logic [9:0] prescale;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [3:0] pin_s3;
        logic [7:0] rdata;
        logic [2:0] tick;
        logic [2:0] phase;
        logic [2:0] pwm1;
        logic [2:0] pwm2;
        logic [7:0] active;
        logic buf_a;
        logic buf_b;
        logic [7:0] lvl;
        logic [7:0] lvl_valid;
    } state_type;

    state_type state_reg;
    state_type state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Source decode per channel
    function automatic clk_src_type decode_src(input logic [1:0] ch, input logic [2:0] sel,
                                               input logic [3:0] mode);
        clk_src_type s;
        s = src_none;
        if (ch != 2'h0 && mode[mode_msb-1] && !mode[mode_msb]) begin
            s = src_phase;
        end else begin
            unique case (sel)
                3'h0: s = src_div1;
                3'h1: s = src_div4;
                3'h2: s = src_div16;
                3'h3: s = src_div64;
                3'h4: s = src_pin_a;
                3'h5: s = src_pin_b;
                3'h6: s = (ch == 2'h1) ? src_div256 : src_pin_c;
                3'h7: s = (ch == 2'h0) ? src_pin_d : ((ch == 2'h2) ? src_div1024 : src_none);
            endcase
        end
        return s;
    endfunction

    // Initial level: field codes 0001-0011 give 0, 0101-0111 give 1
    function automatic logic [1:0] field_level(input logic [3:0] f);
        logic out_en;
        out_en = !f[3] && (f[1:0] != 2'h0);
        return {out_en, f[2]};
    endfunction

    // Fixed ones forced on every write; the mask drops bits a channel lacks
    function automatic logic [7:0] mode_write(input logic [7:0] d, input logic [7:0] mask);
        return mode_fixed_ones | (d & mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] pin_rise;
    clk_src_type src [3];
    logic [3:0] md [3];
    logic [7:0] fields;
    logic [1:0] lv;

    always_comb begin
        state_next = state_reg;
        // Two-stage sync, then edge detect on the second stage only
        state_next.pin_s1 = {ext_clk_pin_d, ext_clk_pin_c, ext_clk_pin_b, ext_clk_pin_a};
        state_next.pin_s2 = state_reg.pin_s1;
        state_next.pin_s3 = state_reg.pin_s2;
        pin_rise = state_reg.pin_s2 & ~state_reg.pin_s3;
        // One free-running prescaler for all channels, so divided ticks line up
        state_next.prescale = state_reg.prescale + 10'h001;

        if (wr_stb) begin
            unique case (addr)
                ch0_mode_off: state_next.mode0 = mode_write(wdata, mode_mask_ch0);
                ch1_mode_off: state_next.mode1 = mode_write(wdata, mode_mask_ch12);
                ch2_mode_off: state_next.mode2 = mode_write(wdata, mode_mask_ch12);
                ch0_func_ab_off: state_next.func0ab = wdata;
                ch0_func_cd_off: state_next.func0cd = wdata;
                ch1_func_off: state_next.func1 = wdata;
                ch2_func_off: state_next.func2 = wdata;
                start_off: state_next.start = wdata[2:0];
                sel0_off: state_next.sel0 = wdata[2:0];
                sel1_off: state_next.sel1 = wdata[2:0];
                sel2_off: state_next.sel2 = wdata[2:0];
                default: ;
            endcase
        end

        state_next.rdata = 8'h00;
        if (rd_stb) begin
            unique case (addr)
                ch0_mode_off: state_next.rdata = state_reg.mode0;
                ch1_mode_off: state_next.rdata = state_reg.mode1;
                ch2_mode_off: state_next.rdata = state_reg.mode2;
                ch0_func_ab_off: state_next.rdata = state_reg.func0ab;
                ch0_func_cd_off: state_next.rdata = state_reg.func0cd;
                ch1_func_off: state_next.rdata = state_reg.func1;
                ch2_func_off: state_next.rdata = state_reg.func2;
                start_off: state_next.rdata = {5'h00, state_reg.start};
                sel0_off: state_next.rdata = {5'h00, state_reg.sel0};
                sel1_off: state_next.rdata = {5'h00, state_reg.sel1};
                sel2_off: state_next.rdata = {5'h00, state_reg.sel2};
                default: state_next.rdata = 8'h00;
            endcase
        end

        md[0] = state_reg.mode0[3:0];
        md[1] = state_reg.mode1[3:0];
        md[2] = state_reg.mode2[3:0];
        src[0] = decode_src(2'h0, state_reg.sel0, md[0]);
        src[1] = decode_src(2'h1, state_reg.sel1, md[1]);
        src[2] = decode_src(2'h2, state_reg.sel2, md[2]);

        for (int c = 0; c < 3; c++) begin
            logic t;
            t = 1'b0;
            unique case (src[c])
                src_div1: t = 1'b1;
                src_div4: t = state_reg.prescale[1:0] == 2'h3;
                src_div16: t = state_reg.prescale[3:0] == 4'hf;
                src_div64: t = state_reg.prescale[5:0] == 6'h3f;
                src_div256: t = state_reg.prescale[7:0] == 8'hff;
                src_div1024: t = state_reg.prescale == prescale_width_max;
                src_pin_a: t = pin_rise[0];
                src_pin_b: t = pin_rise[1];
                src_pin_c: t = pin_rise[2];
                src_pin_d: t = pin_rise[3];
                src_phase: t = 1'b0; // Phase decoder lives in the counter datapath
                src_none: t = 1'b0;
            endcase
            state_next.tick[c] = t & state_reg.start[c];
            // Mode decode; reserved codes and top bit set act as normal
            state_next.phase[c] = (c != 0) && !md[c][3] && md[c][2];
            state_next.pwm1[c] = md[c] == mode_pwm1;
            state_next.pwm2[c] = md[c] == mode_pwm2;
        end

        state_next.buf_a = state_reg.mode0[bfa_pos];
        state_next.buf_b = state_reg.mode0[bfb_pos];
        // C and D drop out of compare/capture while buffering
        state_next.active = 8'hff;
        state_next.active[2] = !state_reg.mode0[bfa_pos];
        state_next.active[3] = !state_reg.mode0[bfb_pos];

        // Order: ch0 a,b,c,d, ch1 a,b, ch2 a,b
        for (int g = 0; g < 8; g++) begin
            int ch;
            fields = 8'h00;
            ch = (g < 4) ? 0 : ((g < 6) ? 1 : 2);
            unique case (g)
                0: fields = {4'h0, state_reg.func0ab[3:0]};
                1: fields = {4'h0, state_reg.func0ab[7:4]};
                2: fields = {4'h0, state_reg.func0cd[3:0]};
                3: fields = {4'h0, state_reg.func0cd[7:4]};
                4: fields = {4'h0, state_reg.func1[3:0]};
                5: fields = {4'h0, state_reg.func1[7:4]};
                6: fields = {4'h0, state_reg.func2[3:0]};
                default: fields = {4'h0, state_reg.func2[7:4]};
            endcase
            lv = field_level(fields[3:0]);
            state_next.lvl[g] = lv[0];
            // Valid when stopped, or in PWM mode 2 as clear level
            state_next.lvl_valid[g] = lv[1] && state_next.active[g]
                && (!state_reg.start[ch] || (md[ch] == mode_pwm2));
        end

        if (hw_standby) begin
            state_next.mode0 = mode_reset;
            state_next.mode1 = mode_reset;
            state_next.mode2 = mode_reset;
            state_next.func0ab = func_reset;
            state_next.func0cd = func_reset;
            state_next.func1 = func_reset;
            state_next.func2 = func_reset;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
            state_reg.mode0 <= mode_reset;
            state_reg.mode1 <= mode_reset;
            state_reg.mode2 <= mode_reset;
            state_reg.func0ab <= func_reset;
            state_reg.func0cd <= func_reset;
            state_reg.func1 <= func_reset;
            state_reg.func2 <= func_reset;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign count_tick = state_reg.tick;
    assign phase_mode = state_reg.phase;
    assign pwm1_mode = state_reg.pwm1;
    assign pwm2_mode = state_reg.pwm2;
    assign greg_active = state_reg.active;
    assign buf_a_en = state_reg.buf_a;
    assign buf_b_en = state_reg.buf_b;
    assign init_level = state_reg.lvl;
    assign init_level_valid = state_reg.lvl_valid;

    ////////////////////////////////////////////////////////////////////////////
    a_mode_top_ones: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.mode0[7:6] == 2'h3 && state_reg.mode1[7:6] == 2'h3 && state_reg.mode2[7:6] == 2'h3)
        else $error("mode top bits not one");
    a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
        wr_stb && addr == ch1_mode_off |=> state_reg.mode1[5:4] == 2'h0)
        else $error("ch1 reserved bits written");
    a_standby_mode: assert property (@(posedge clk) disable iff (sys_rst)
        hw_standby |=> state_reg.mode0 == mode_reset && state_reg.mode1 == mode_reset
        && state_reg.mode2 == mode_reset)
        else $error("standby mode value wrong");
    a_standby_func: assert property (@(posedge clk) disable iff (sys_rst)
        hw_standby |=> state_reg.func0cd == func_reset && state_reg.func1 == func_reset
        && state_reg.func0ab == func_reset && state_reg.func2 == func_reset)
        else $error("standby function value wrong");
    a_buf_d_off: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.mode0[bfb_pos] |=> !greg_active[3] && !init_level_valid[3])
        else $error("buffer D still active");
    a_buf_c_off: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.mode0[bfa_pos] |=> !greg_active[2])
        else $error("buffer C still active");
    a_phase_no_tick: assert property (@(posedge clk) disable iff (sys_rst)
        phase_mode[1] |-> !count_tick[1])
        else $error("tick in phase mode");
    a_div1_tick: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel0 == 3'h0 && state_reg.start[0] && !wr_stb ##1 !wr_stb |=> count_tick[0])
        else $error("div1 tick missing");
    a_pin_sync: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel2 == 3'h4 && md[2] == 4'h0 && state_reg.start[2] && !wr_stb && !ext_clk_pin_a
        ##1 ext_clk_pin_a && !wr_stb ##1 !wr_stb |-> ##2 count_tick[2])
        else $error("pin edge timing");

    ////////////////////////////////////////////////////////////////////////////
    // Clock sources: one tick per divider period, none for ch1 code 7 or ch2 phase mode
    a_div4_hit: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel0 == 3'h1 && state_reg.start[0] && state_reg.prescale[1:0] == 2'h3 |=> count_tick[0])
        else $error("div4 tick missing");
    a_div4_miss: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel0 == 3'h1 && state_reg.start[0] && state_reg.prescale[1:0] != 2'h3 |=> !count_tick[0])
        else $error("div4 tick out of step");
    a_div256_hit: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel1 == 3'h6 && md[1][3:2] != 2'h1 && state_reg.start[1]
        && state_reg.prescale[7:0] == 8'hff |=> count_tick[1])
        else $error("div256 tick missing");
    a_div256_miss: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel1 == 3'h6 && md[1][3:2] != 2'h1 && state_reg.start[1]
        && state_reg.prescale[7:0] != 8'hff |=> !count_tick[1])
        else $error("div256 tick out of step");
    a_ch1_no_source: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel1 == 3'h7 |=> !count_tick[1])
        else $error("prohibited code ticks");
    a_div64_ch2: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel2 == 3'h3 && md[2][3:2] != 2'h1 && state_reg.start[2]
        && state_reg.prescale[5:0] == 6'h3f |=> count_tick[2])
        else $error("div64 tick missing");
    a_div1024_hit: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel2 == 3'h7 && md[2][3:2] != 2'h1 && state_reg.start[2]
        && state_reg.prescale == prescale_width_max |=> count_tick[2])
        else $error("div1024 tick missing");
    a_div1024_miss: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.sel2 == 3'h7 && md[2][3:2] != 2'h1 && state_reg.start[2]
        && state_reg.prescale != prescale_width_max |=> !count_tick[2])
        else $error("div1024 tick out of step");
    a_phase2_no_tick: assert property (@(posedge clk) disable iff (sys_rst)
        phase_mode[2] |-> !count_tick[2])
        else $error("tick in ch2 phase mode");

    ////////////////////////////////////////////////////////////////////////////
    // Mode flags follow the stored mode field one cycle later
    a_pwm1_flag: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.mode1[3:0] == mode_pwm1 |=> pwm1_mode[1] && !pwm2_mode[1] && !phase_mode[1])
        else $error("pwm1 flag wrong");
    a_pwm2_flag: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.mode0[3:0] == mode_pwm2 |=> pwm2_mode[0] && !pwm1_mode[0] && !phase_mode[0])
        else $error("pwm2 flag wrong");
    a_phase_flag: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.mode2[3:2] == 2'h1 |=> phase_mode[2] && !pwm1_mode[2] && !pwm2_mode[2])
        else $error("phase flag wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    a_read_func: assert property (@(posedge clk) disable iff (sys_rst)
        rd_stb && addr == ch0_func_ab_off |=> rdata == $past(state_reg.func0ab))
        else $error("function read wrong");
    a_read_mode: assert property (@(posedge clk) disable iff (sys_rst)
        rd_stb && addr == ch2_mode_off |=> rdata[7:4] == 4'hc)
        else $error("mode read fixed bits wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Initial pin levels
    a_lvl_stopped: assert property (@(posedge clk) disable iff (sys_rst)
        !state_reg.start[0] && !state_reg.func0ab[3] && state_reg.func0ab[1:0] != 2'h0 |=> init_level_valid[0])
        else $error("level not valid while stopped");
    a_lvl_running: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.start[0] && state_reg.mode0[3:0] != mode_pwm2 |=> init_level_valid[1:0] == 2'h0)
        else $error("level valid while running");
    a_pwm2_level: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.start[0] && state_reg.mode0[3:0] == mode_pwm2
        && !state_reg.func0ab[3] && state_reg.func0ab[1:0] != 2'h0 |=> init_level_valid[0])
        else $error("pwm2 clear level missing");
    a_buf_field_c: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg.mode0[bfa_pos] |=> !init_level_valid[2])
        else $error("buffer C field still used");
endmodule

// *** tb/tpu_cfg_bench.sv ***
// Purpose: Self-checking bench for the timer configuration block
// Assumes: Register indices and start/select offsets as in the package
// Notes: Reads are checked from a queue one cycle after the strobe
`timescale 1ns/1ps
module tpu_cfg_bench
    import tpu_cfg_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hw_standby = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [3:0] pins = 4'h0;
    logic [7:0] rdata;
    logic [2:0] count_tick, phase_mode, pwm1_mode, pwm2_mode;
    logic [7:0] greg_active, init_level, init_level_valid;
    logic buf_a_en, buf_b_en;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    int tick_cnt[3];
    int bad_count = 0;
    int checked = 0;

    always #12.5 clk = ~clk;

    tpu_cfg i_tpu_cfg (.clk(clk), .sys_rst(sys_rst), .hw_standby(hw_standby), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ext_clk_pin_a(pins[0]), .ext_clk_pin_b(pins[1]),
        .ext_clk_pin_c(pins[2]), .ext_clk_pin_d(pins[3]), .count_tick(count_tick), .phase_mode(phase_mode),
        .pwm1_mode(pwm1_mode), .pwm2_mode(pwm2_mode), .greg_active(greg_active), .buf_a_en(buf_a_en),
        .buf_b_en(buf_b_en), .init_level(init_level), .init_level_valid(init_level_valid));

    task automatic check(logic [15:0] seen, logic [15:0] exp, string msg);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Bus tasks; wr and rd leave their strobe up so calls may run back to back, idle drops both
    task automatic wr(logic [3:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(logic [3:0] a, logic [7:0] e);
        addr <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        exp_q.push_back(e);
        @(posedge clk);
    endtask

    task automatic idle(int n);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd_stb;
    always @(negedge clk) begin
        if (rd_seen) begin
            check({8'h00, rdata}, {8'h00, exp_q.pop_front()}, "read data");
        end
        for (int i = 0; i < 3; i++) begin
            if (count_tick[i] === 1'b1) begin
                tick_cnt[i]++;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Divided ticks over 1024 cycles, pin ticks over 2k pulses; a window of whole periods gives an exact count
    function automatic int divisor(int ch, int code);
        if (code < 4) return 4 ** code;
        if (ch == 1 && code == 6) return 256;
        if (ch == 1 && code == 7) return 0;
        if (ch == 2 && code == 7) return 1024;
        return -1;
    endfunction

    task automatic measure(int ch, int code, bit run);
        int d;
        int k;
        int e;
        d = divisor(ch, code);
        k = 1 + $urandom % 5;
        wr(sel0_off + 4'(ch), 8'(code));
        idle(40);
        tick_cnt[ch] = 0;
        if (d < 0) begin
            // Other pins pulse too, so a wrong pick shows
            for (int j = 0; j < 2 * k; j++) begin
                pins <= (j < k) ? 4'hf : ~(4'h1 << (code - 4));
                repeat (4) @(posedge clk);
                pins <= 4'h0;
                repeat (4) @(posedge clk);
            end
            idle(8);
        end else begin
            idle(1024);
        end
        e = !run ? 0 : (d < 0 ? k : (d == 0 ? 0 : 1024 / d));
        check(16'(tick_cnt[ch]), 16'(e), "tick count");
    endtask

    initial begin
        #(25ns * 100000);
        bad_count++;
        $display("FAIL %0t run too long", $time);
        stop_test();
    end

    initial begin
        logic [7:0] w;
        void'($urandom(31));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), (a < 3) ? mode_reset : 8'h00);
        end
        // Masks of the mode registers, software keeps the reserved mode bits clear
        for (int n = 0; n < 12; n++) begin
            w = 8'($urandom);
            w = (n % 3 == 0) ? (w & 8'hf3) : (w & 8'hf7);
            wr(4'(n % 3), w);
            rd(4'(n % 3), (w & ((n % 3 == 0) ? mode_mask_ch0 : mode_mask_ch12)) | mode_fixed_ones);
            wr(4'(3 + n % 4), w);
            wr(4'hf, 8'hff);
            rd(4'(3 + n % 4), w);
            rd(4'hf, 8'h00);
        end
        for (int a = 0; a < 7; a++) begin
            wr(4'(a), 8'h00);
        end
        // Mode codes 0-3 on channel 0, 0-7 on channels 1 and 2; counters are stopped
        for (int ch = 0; ch < 3; ch++) begin
            for (int m = 0; m < ((ch == 0) ? 4 : 8); m++) begin
                wr(4'(ch), 8'(m));
                idle(3);
                check(16'(phase_mode[ch]), 16'(m >= 4), "phase flag");
                check(16'(pwm1_mode[ch]), 16'(m == 2), "pwm1 flag");
                check(16'(pwm2_mode[ch]), 16'(m == 3), "pwm2 flag");
            end
            wr(4'(ch), 8'h00);
        end
        // Initial levels: a init 0, b init 1, c and d init 0
        wr(ch0_func_ab_off, 8'h51);
        wr(ch0_func_cd_off, 8'h11);
        idle(3);
        check({8'h00, init_level_valid}, 16'h000f, "valid while stopped");
        check({8'h00, init_level}, 16'h0002, "initial level");
        wr(start_off, 8'h01);
        idle(3);
        check(16'(init_level_valid[1:0]), 16'h0000, "valid while running");
        wr(start_off, 8'h00);
        wr(ch0_mode_off, 8'h03);
        wr(start_off, 8'h01);
        idle(3);
        check(16'(init_level_valid[1:0]), 16'h0003, "pwm2 clear level");
        wr(start_off, 8'h00);
        wr(ch0_mode_off, 8'h30);
        idle(3);
        check({14'h0, buf_b_en, buf_a_en}, 16'h0003, "buffer pairing");
        check({8'h00, greg_active}, 16'h00f3, "buffered regs idle");
        check(16'(init_level_valid[3:2]), 16'h0000, "buffered field ignored");
        // Standby forces the reset values
        wr(ch1_func_off, 8'h77);
        hw_standby <= 1'b1;
        idle(2);
        hw_standby <= 1'b0;
        rd(ch0_mode_off, mode_reset);
        rd(ch1_func_off, func_reset);
        rd(ch0_func_cd_off, func_reset);
        idle(2);
        measure(0, 0, 0);
        wr(start_off, 8'h07);
        for (int ch = 0; ch < 3; ch++) begin
            for (int c = 0; c < 8; c++) begin
                measure(ch, c, 1);
            end
        end
        for (int ch = 1; ch < 3; ch++) begin
            wr(start_off, 8'h00);
            wr(4'(ch), 8'h04);
            wr(start_off, 8'h07);
            measure(ch, 0, 0);
            wr(start_off, 8'h00);
            wr(4'(ch), 8'h00);
        end
        idle(4);
        stop_test();
    end
endmodule
